// ===== shared/xps_pkg.sv
// Shared constants and types for the crosspoint serial control block.
package xps_pkg;

    // Number of switch outputs and width of an input index.
    localparam int unsigned XPS_NUM_OUT = 8;
    localparam int unsigned XPS_SEL_W = 4;

    // Width of an output index within an addressed word.
    localparam int unsigned XPS_OUT_IDX_W = 3;

    // Bits in one serial-mode frame and in one addressed word.
    localparam int unsigned XPS_FRAME_BITS = 40;
    localparam int unsigned XPS_WORD_BITS = 8;

    // Field positions inside an addressed word, first bit clocked is bit 0.
    localparam int unsigned XPS_AW_OUT_LSB = 0;
    localparam int unsigned XPS_AW_SEL_LSB = 3;
    localparam int unsigned XPS_AW_OFF_POS = 7;

    // Last value of the addressed-word bit counter.
    localparam logic [2:0] XPS_AW_LAST = 3'h7;

    // One output's setting: the off bit above a four-bit input index.
    typedef struct packed {
        logic off;
        logic [XPS_SEL_W-1:0] sel;
    } xps_route_t;

    // A whole bank; entry k holds frame bits 5k to 5k+4.
    typedef xps_route_t [XPS_NUM_OUT-1:0] xps_bank_t;

    // Synchronised pin bundle, one bit per pin.
    typedef struct packed {
        logic sclk;
        logic sdin;
        logic cs_b;
        logic cfg;
        logic mode;
        logic clear;
        logic bcast;
    } xps_pins_t;

    // Pin levels assumed during reset: chip select idle high, rest low.
    localparam xps_pins_t XPS_PINS_RST = '{sclk: 1'b0, sdin: 1'b0, cs_b: 1'b1,
        cfg: 1'b0, mode: 1'b0, clear: 1'b0, bcast: 1'b0};

    // Values after reset or clear, and the broadcast setting.
    localparam xps_route_t XPS_ROUTE_OFF = '{off: 1'b1, sel: 4'h0};
    localparam xps_route_t XPS_ROUTE_BCAST = '{off: 1'b0, sel: 4'h0};
    localparam logic [2:0] XPS_CNT_RST = 3'h0;

endpackage : xps_pkg

// ===== verilog/xps_pin_sync.sv
// Two-stage synchroniser with edge detection for the control pins.
`timescale 1ns/1ns
module xps_pin_sync
    import xps_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    // Raw pins from outside the clock domain.
    input wire xps_pins_t pins_raw,
    // Synchronised levels and one-cycle edge pulses.
    output xps_pins_t pins_lvl,
    output xps_pins_t pins_rise,
    output xps_pins_t pins_fall
);

    // First stage; read only by the second stage.
    xps_pins_t meta_q;
    // Second stage, the first usable level.
    xps_pins_t sync_q;
    // Previous usable level, for edge detection.
    xps_pins_t hist_q;

    localparam int unsigned PIN_W = $bits(xps_pins_t);

    ////////////////////////////////////////////////////////////////////////
    // Each pin gets its own chain so that no bit can skew into another.
    generate
        for (genvar i = 0; i < PIN_W; i++) begin : g_pin
            // Synchroniser and history flops for one pin.
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    meta_q[i] <= XPS_PINS_RST[i];
                    sync_q[i] <= XPS_PINS_RST[i];
                    hist_q[i] <= XPS_PINS_RST[i];
                end else begin
                    meta_q[i] <= pins_raw[i];
                    sync_q[i] <= meta_q[i];
                    hist_q[i] <= sync_q[i];
                end
            end
            // Edges compare the two settled stages only.
            assign pins_lvl[i] = sync_q[i];
            assign pins_rise[i] = sync_q[i] & ~hist_q[i];
            assign pins_fall[i] = ~sync_q[i] & hist_q[i];
        end
    endgenerate

endmodule : xps_pin_sync

// ===== verilog/xps_ctrl.sv
// Serial control logic of a 16-input, 8-output crosspoint switch.
//
// What this block does
// - One active register per output drives switching.
// - Active bank changes only by copy or pins.
// - Load bank mirrors active bank, filled serially.
// - Chip select high ignores clock and data.
// - First rising edge arms; next falling captures.
// - Every bit sampled on a serial clock fall.
// - Configure pulse copies load bank to active.
// - Configure works whatever chip select shows.
// - Repeated configure without new data changes nothing.
// - Mode high: addressed word updates one output.
// - Mode low: one frame loads every output.
// - Each output picks one input; inputs shareable.
// - Output marked off goes high impedance.
// - Frame: five bits per output, index LSB first.
// - Word: output index, input index, off bit.
// - Clear sets index zero, all outputs off.
// - Broadcast turns all outputs on to input zero.
`timescale 1ns/1ns
module xps_ctrl
    import xps_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    // Serial bus pins.
    input wire logic sclk,
    input wire logic sdin,
    input wire logic cs_b,
    // Control pins acting outside the serial bus.
    input wire logic cfg,
    input wire logic mode,
    input wire logic clear,
    input wire logic broadcast_input_zero,
    // Serial data out for chaining.
    output logic sdout_q,
    // Active bank driving the switch matrix.
    output xps_bank_t active_q
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation.

    // Raw pin bundle handed to the synchroniser.
    xps_pins_t pins_raw;
    // Settled levels and edge pulses.
    xps_pins_t lvl;
    xps_pins_t rise;
    xps_pins_t fall;

    assign pins_raw = '{sclk: sclk, sdin: sdin, cs_b: cs_b, cfg: cfg,
        mode: mode, clear: clear, bcast: broadcast_input_zero};

    // Data and clock share one delay, so data stays aligned to its edge.
    xps_pin_sync u_sync (
        .core_clk (core_clk),
        .rst_b (rst_b),
        .pins_raw (pins_raw),
        .pins_lvl (lvl),
        .pins_rise (rise),
        .pins_fall (fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Receive state.

    // Reception armed after the first rising clock under chip select.
    logic armed_q;
    // Bit position within an addressed word.
    logic [2:0] cnt_q;
    // Addressed word being assembled, newest bit at the top.
    logic [XPS_WORD_BITS-1:0] aw_q;
    // Load bank, a 40-bit shift register in serial mode.
    xps_bank_t load_q;
    // The same load bank seen as one flat vector, bit j being frame bit j.
    logic [XPS_FRAME_BITS-1:0] load_flat;

    // Chip select asserted.
    logic cs_low;
    // A bit is taken in this cycle.
    logic shift_en;
    // The addressed word completes in this cycle.
    logic aw_done;
    // Addressed word including the bit now arriving.
    logic [XPS_WORD_BITS-1:0] aw_d;
    // Output index and new setting decoded from that word.
    logic [XPS_OUT_IDX_W-1:0] aw_out;
    xps_route_t aw_route;

    assign cs_low = ~lvl.cs_b;
    // Only falling edges after arming take data.
    assign shift_en = armed_q & cs_low & fall.sclk;
    assign aw_done = shift_en & lvl.mode & (cnt_q == XPS_AW_LAST);
    assign aw_d = {lvl.sdin, aw_q[XPS_WORD_BITS-1:1]};
    // First bit clocked is bit 0, so fields read LSB first.
    assign aw_out = aw_d[XPS_AW_OUT_LSB +: XPS_OUT_IDX_W];
    assign aw_route = '{off: aw_d[XPS_AW_OFF_POS],
        sel: aw_d[XPS_AW_SEL_LSB +: XPS_SEL_W]};
    // Indexing the packed bank picks whole entries, so shifting uses this flat view.
    assign load_flat = load_q;

    // Arming: a rise under chip select arms; chip select high disarms.
    // A falling edge seen before the first rise is deliberately dropped.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            armed_q <= 1'b0;
        end else if (!cs_low) begin
            armed_q <= 1'b0;
        end else if (rise.sclk) begin
            armed_q <= 1'b1;
        end
    end

    // Addressed word assembly; restarts whenever chip select drops away.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= XPS_CNT_RST;
            aw_q <= '0;
        end else if (!cs_low) begin
            cnt_q <= XPS_CNT_RST;
        end else if (shift_en && lvl.mode) begin
            cnt_q <= cnt_q + 3'h1;
            aw_q <= aw_d;
        end
    end

    // Load bank: clear wins, then serial shift or addressed update.
    // Shifting right puts frame bit 0 at the far end after 40 bits.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            load_q <= {XPS_NUM_OUT{XPS_ROUTE_OFF}};
        end else if (lvl.clear) begin
            load_q <= {XPS_NUM_OUT{XPS_ROUTE_OFF}};
        end else if (shift_en && !lvl.mode) begin
            load_q <= {lvl.sdin, load_flat[XPS_FRAME_BITS-1:1]};
        end else if (aw_done) begin
            load_q[aw_out] <= aw_route;
        end
    end

    // Serial out follows the bit at the far end of the load register.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sdout_q <= 1'b0;
        end else begin
            sdout_q <= load_q[0].sel[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Active bank, the only state the switch matrix sees.

    // Clear over broadcast over configure; configure ignores chip select.
    // Each entry holds one index, so an output has exactly one input.
    // Broadcast acts as a level and writes only this bank, so once the pin
    // drops the outputs keep the broadcast setting until the next configure or clear.
    // Clear must also empty the load bank, or a later configure would bring
    // the old routes back; that is why both banks share the clear branch.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            active_q <= {XPS_NUM_OUT{XPS_ROUTE_OFF}};
        end else if (lvl.clear) begin
            active_q <= {XPS_NUM_OUT{XPS_ROUTE_OFF}};
        end else if (lvl.bcast) begin
            active_q <= {XPS_NUM_OUT{XPS_ROUTE_BCAST}};
        end else if (rise.cfg) begin
            active_q <= load_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // Configure copies exactly the load bank seen at the pulse.
    chk_cfg_copy: assert property (
        rise.cfg && !lvl.clear && !lvl.bcast |=> active_q == $past(load_q))
        else $error("configure did not copy load bank");

    // Without configure, clear or broadcast the active bank holds.
    chk_active_hold: assert property (
        !rise.cfg && !lvl.clear && !lvl.bcast |=> $stable(active_q))
        else $error("active bank changed without cause");

    // A second configure with no new data leaves the switch alone.
    chk_cfg_repeat: assert property (
        rise.cfg && active_q == load_q && !lvl.clear && !lvl.bcast
        |=> $stable(active_q))
        else $error("repeated configure changed state");

    // Select high freezes the load bank whatever the clock does.
    chk_cs_ignore: assert property (
        lvl.cs_b && !lvl.clear |=> $stable(load_q) && !armed_q)
        else $error("load bank moved with select high");

    // A rise under chip select arms reception by the next cycle.
    chk_arm_rise: assert property (
        cs_low && rise.sclk |=> armed_q)
        else $error("reception not armed by rising edge");

    // A falling edge before arming takes no bit.
    chk_no_early: assert property (
        !armed_q && !lvl.clear |=> $stable(load_q))
        else $error("bit taken before arming");

    // Serial mode shifts the new bit in at the top.
    chk_serial_shift: assert property (
        shift_en && !lvl.mode && !lvl.clear
        |=> load_flat == {$past(lvl.sdin), $past(load_flat[XPS_FRAME_BITS-1:1])})
        else $error("serial shift wrong");

    // A complete addressed word lands in the addressed entry only.
    chk_addr_write: assert property (
        aw_done && !lvl.clear |=> load_q[$past(aw_out)] == $past(aw_route))
        else $error("addressed word not written");

    // Clear held two cycles leaves every output off on input zero in the cycle after.
    chk_clear_all: assert property (
        lvl.clear [*2] |=> active_q == {XPS_NUM_OUT{XPS_ROUTE_OFF}}
        && load_q == {XPS_NUM_OUT{XPS_ROUTE_OFF}})
        else $error("clear did not turn all off");

    // Broadcast turns every output on to input zero.
    chk_bcast_all: assert property (
        lvl.bcast && !lvl.clear |=> active_q == {XPS_NUM_OUT{XPS_ROUTE_BCAST}})
        else $error("broadcast not applied");

    // Serial out trails the far end of the load register by one cycle.
    chk_sdout_far: assert property (
        ##1 sdout_q == $past(load_q[0].sel[0]))
        else $error("serial out not far end bit");

    // Chip select high restarts the addressed word count.
    chk_cnt_restart: assert property (
        lvl.cs_b |=> cnt_q == XPS_CNT_RST)
        else $error("word count kept with select high");

    // Once armed, reception stays armed while chip select stays low.
    chk_arm_hold: assert property (
        armed_q && cs_low |=> armed_q)
        else $error("reception disarmed under select");

    // Only a falling serial clock can move the load bank, clear aside.
    chk_fall_only: assert property (
        !fall.sclk && !lvl.clear |=> $stable(load_q))
        else $error("load bank moved without falling edge");

    // Addressed bits gather with the first bit ending at the bottom.
    chk_aw_shift: assert property (
        shift_en && lvl.mode |=> aw_q == $past(aw_d))
        else $error("addressed word assembled wrongly");

    // In addressed mode a bit short of the eighth leaves the load bank alone.
    chk_addr_partial: assert property (
        shift_en && lvl.mode && !aw_done && !lvl.clear |=> $stable(load_q))
        else $error("partial addressed word changed load bank");

    // Serial mode never advances the addressed word count.
    chk_serial_count: assert property (
        cs_low && !lvl.mode |=> $stable(cnt_q))
        else $error("word count moved in serial mode");

    // Broadcast writes the active bank only, never the load bank.
    chk_bcast_load: assert property (
        lvl.bcast && !lvl.clear && !shift_en && !aw_done |=> $stable(load_q))
        else $error("broadcast touched load bank");

    // Clear wins over configure and broadcast in the very next cycle.
    chk_clear_first: assert property (
        lvl.clear |=> active_q == {XPS_NUM_OUT{XPS_ROUTE_OFF}}
        && load_q == {XPS_NUM_OUT{XPS_ROUTE_OFF}})
        else $error("clear lost to another cause");

    // Addressed write leaves every other entry of the load bank alone.
    generate
        for (genvar k = 0; k < XPS_NUM_OUT; k++) begin : g_entry_chk
            // Entry k holds unless it is the one addressed.
            chk_entry_keep: assert property (
                aw_done && !lvl.clear && aw_out != k |=> $stable(load_q[k]))
                else $error("addressed word touched another entry");
        end
    endgenerate

    // Main scenarios.
    cov_serial_cfg: cover property (shift_en && !lvl.mode ##[1:1000] rise.cfg);
    cov_cfg_deselected: cover property (rise.cfg && lvl.cs_b);
    cov_addr_word: cover property (aw_done);
    cov_clear: cover property (lvl.clear);
    cov_bcast: cover property (lvl.bcast && !lvl.clear);

endmodule : xps_ctrl

// ===== sim/xps_host_model.sv
// Behavioural host that drives the serial bus of the crosspoint control block.
`timescale 1ns/1ns
module xps_host_model (
    // Serial bus pins toward the device.
    output logic sclk,
    output logic sdin,
    output logic cs_b
);
    // Half period of the 800 ns link clock.
    localparam int HALF = 400;
    ////////////////////////////////////////////////////////////////////////////
    // Idle bus: select high and the clock parked low between frames.
    initial begin
        sclk = 1'b0;
        sdin = 1'b0;
        // A lone device sits on this bus, so no joined outputs are enabled together.
        cs_b = 1'b1;
    end
    // Sends n bits, bit 0 first; data is set on a rise and held past the fall.
    task automatic send(input logic [39:0] d, input int n);
        cs_b = 1'b0;
        #HALF;
        for (int i = 0; i < n; i++) begin
            sdin = d[i];
            sclk = 1'b1;
            #HALF;
            sclk = 1'b0;
            #HALF;
        end
        // Select rises first, then one extra rise so no stray bit is taken.
        cs_b = 1'b1;
        #HALF;
        sclk = 1'b1;
        #HALF;
        sclk = 1'b0;
        // Released data must not keep showing the last bit.
        sdin = ~sdin;
        #HALF;
    endtask : send
    // Toggles clock and data with select high; the device must not react.
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            sdin = ~sdin;
            sclk = 1'b1;
            #HALF;
            sclk = 1'b0;
            #HALF;
        end
    endtask : stray
endmodule : xps_host_model

// ===== sim/crosspoint_serial_control_tb_top.sv
// Self-checking testbench for the crosspoint serial control block.
`timescale 1ns/1ns
`define XPS_CMP(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module crosspoint_serial_control_tb_top
    import xps_pkg::*;
;
    // Clock, reset and control pins driven by the bench.
    logic core_clk = 1'b0;
    logic rst_b;
    logic cfg;
    logic mode;
    logic clear;
    logic bcast_pin;
    // Serial bus driven by the host model.
    logic sclk;
    logic sdin;
    logic cs_b;
    // Device outputs.
    logic sdout_q;
    xps_bank_t active_q;
    // Models of the load and active banks, and the expectation queue.
    logic [39:0] lm;
    logic [39:0] am;
    logic [39:0] frame;
    logic [7:0] w;
    logic [40:0] e;
    logic [40:0] exp_q[$];
    int miscompares = 0;
    int comparisons = 0;
    event chk_ev;
    ////////////////////////////////////////////////////////////////////////////
    // The 100 ns core clock.
    always #50 core_clk = ~core_clk;
    xps_ctrl uut (.core_clk(core_clk), .rst_b(rst_b), .sclk(sclk), .sdin(sdin),
        .cs_b(cs_b), .cfg(cfg), .mode(mode), .clear(clear),
        .broadcast_input_zero(bcast_pin), .sdout_q(sdout_q), .active_q(active_q));
    xps_host_model host (.sclk(sclk), .sdin(sdin), .cs_b(cs_b));
    ////////////////////////////////////////////////////////////////////////////
    // Queues the modelled state and lets the pins settle through the synchroniser.
    task automatic note();
        exp_q.push_back({lm[0], am});
        repeat (8) @(posedge core_clk);
        #10;
        -> chk_ev;
    endtask : note
    // Pulses the configure pin; the model copies the load bank.
    task automatic cfg_go();
        @(posedge core_clk) #10 cfg = 1'b1;
        repeat (4) @(posedge core_clk);
        #10;
        cfg = 1'b0;
        am = lm;
    endtask : cfg_go
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////
    // Watcher: each result is compared with the oldest queued note.
    always @(chk_ev) begin
        e = exp_q.pop_front();
        `XPS_CMP({sdout_q, active_q}, e)
    end
    // A hung run counts as a mismatch and still reaches the verdict.
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        rst_b = 1'b0;
        cfg = 1'b0;
        mode = 1'b0;
        clear = 1'b0;
        bcast_pin = 1'b0;
        lm = {8{XPS_ROUTE_OFF}};
        am = lm;
        void'($urandom(32'h00174932));
        repeat (16) @(posedge core_clk);
        #10;
        rst_b = 1'b1;
        note();
        $display("test reset done");
        // A full frame stays in the load bank until configured.
        frame = {8'($urandom), $urandom};
        host.send(frame, 40);
        lm = frame;
        note();
        cfg_go();
        note();
        cfg_go();
        note();
        host.stray(6);
        cfg_go();
        note();
        $display("test serial done");
        // Addressed words, one per output, each touching only its entry.
        @(posedge core_clk) #10 mode = 1'b1;
        for (int k = 0; k < 8; k++) begin
            w = 8'($urandom);
            w[2:0] = 3'(k);
            host.send({32'h0, w}, 8);
            lm[5*k +: 5] = w[7:3];
            cfg_go();
            note();
        end
        $display("test addressed done");
        // Broadcast forces the active bank only, and the value outlasts the pin.
        @(posedge core_clk) #10 bcast_pin = 1'b1;
        am = {8{XPS_ROUTE_BCAST}};
        note();
        @(posedge core_clk) #10 bcast_pin = 1'b0;
        note();
        $display("test broadcast done");
        // Clear empties both banks, so a later configure keeps all outputs off.
        @(posedge core_clk) #10 clear = 1'b1;
        lm = {8{XPS_ROUTE_OFF}};
        am = lm;
        note();
        @(posedge core_clk) #10 clear = 1'b0;
        cfg_go();
        note();
        $display("test clear done");
        final_report();
    end
endmodule : crosspoint_serial_control_tb_top
